// [sc_pkg.sv]
// shared constants for the serial channel: register map, fields, modes, timing
package sc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_TBUF       = 8'h04;
  localparam logic [7:0]  REG_RBUF       = 8'h08;
  localparam logic [7:0]  REG_BAUD       = 8'h0c;
  localparam logic [7:0]  REG_FLAG       = 8'h10;
  // serial_control_register fields
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_STOP2     = 3;
  localparam int          CTRL_REN       = 4;
  localparam int          CTRL_PEN       = 5;
  localparam int          CTRL_FEN       = 6;
  localparam int          CTRL_OEN       = 7;
  localparam int          CTRL_PE        = 8;
  localparam int          CTRL_FE        = 9;
  localparam int          CTRL_OE        = 10;
  localparam int          CTRL_ODD       = 12;
  localparam int          CTRL_BRS       = 13;
  localparam int          CTRL_RUN       = 15;
  // flag register fields
  localparam int          FLAG_TBIR      = 0;
  localparam int          FLAG_TIR       = 1;
  localparam int          FLAG_RIR       = 2;
  localparam int          FLAG_EIR       = 3;
  localparam int          FLAG_TX_BUSY   = 4;
  localparam int          FLAG_RX_BUSY   = 5;
  localparam int          FLAG_RBUF_FULL = 6;
  // reset values
  localparam logic [15:0] CTRL_RST       = 16'h0000;
  localparam logic [12:0] BAUD_RST       = 13'h0000;
  localparam logic [8:0]  BUF_RST        = 9'h000;
  // mode_select_field encodings
  localparam logic [2:0]  MODE_SYNC      = 3'h0;
  localparam logic [2:0]  MODE_8         = 3'h1;
  localparam logic [2:0]  MODE_7P        = 3'h3;
  localparam logic [2:0]  MODE_9         = 3'h4;
  localparam logic [2:0]  MODE_8W        = 3'h5;
  localparam logic [2:0]  MODE_8P        = 3'h7;
  // frame and timing counts
  localparam logic [3:0]  DATA8          = 4'h8;
  localparam logic [3:0]  DATA9          = 4'h9;
  localparam logic [3:0]  SYNC_BITS      = 4'h8;
  localparam logic [1:0]  DIV3_SKIP      = 2'h2;
  localparam logic [3:0]  ASYNC_LAST_PH  = 4'hf;
  localparam logic [3:0]  SAMPLE_A       = 4'h6;
  localparam logic [3:0]  SAMPLE_B       = 4'h7;
  localparam logic [3:0]  SAMPLE_C       = 4'h8;
  localparam logic [1:0]  SYNC_RISE_PH   = 2'h1;
  localparam logic [1:0]  SYNC_LAST_PH   = 2'h3;
  typedef enum {X_IDLE, X_ASYNC_TX, X_SYNC_TX, X_SYNC_RX} sc_xfer_state_type;
  typedef enum {R_IDLE, R_BUSY} sc_rx_state_type;
endpackage : sc_pkg

// [sc_serial_channel.sv]
// serial channel: sync half-duplex and async modes, error detection, baud generator
`timescale 1ns/1ps

// Summary of operation
// R1: mode field all zero selects synchronous half-duplex operation.
// R2: synchronous transfers move 8 bits; shift clock toggles only while shifting.
// R3: sync data uses the receive data pin; shift clock leaves on the transmit pin.
// R4: sync transmit starts within 4 state times when run set, receiver off.
// R5: idle transmitter takes buffer into shift register at once, raising buffer flag.
// R6: after eighth sync bit both pins go high, done flag set, shifting stops.
// R7: setting receiver enable starts sync reception, shifting data in with own clock.
// R8: after eighth bit: copy to receive buffer, receive flag, clear enable, stop.
// R9: clearing receiver enable mid-byte still completes byte and its flags.
// R10: transmit buffer write during sync reception is ignored, no transmission.
// R11: enabled error at completion raises error flag with receive flag.
// R12: async only: enabled framing check flags any low stop bit.
// R13: async parity modes: enabled parity check flags a mismatching parity bit.
// R14: enabled overrun check flags a frame completing before previous byte read.
// R15: baud counter is 13-bit, counts down at half clock, only while run set.
// R16: each underflow gives one tick and reloads from the reload register.
// R17: third select passes two of every three generator ticks.
// R18: baud read returns counter, top bits zero; write updates reload value.
// R19: baud write reloads counter, deferred until run bit is set.
// R20: async tick is sixteen times bit rate.
// R21: async bits sampled on seventh, eighth and ninth tick, majority kept.
// R22: sync tick is four times bit rate.
// R23: on overrun the new character replaces the unread one.
// R24: status flags stay until software clears; error flag clears separately.
// R25: sync data changes on falling shift clock and is sampled on rising.
module sc_serial_channel (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             txd_o,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe_o,
  output logic             tx_buf_flag_o,
  output logic             tx_done_flag_o,
  output logic             rx_done_flag_o,
  output logic             err_flag_o
);

  function automatic logic [15:0] sc_merge(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  sel);
    sc_merge = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : sc_merge

  logic [15:0]                   ctrl;
  logic [8:0]                    tbuf;
  logic                          tbuf_full;
  logic [8:0]                    rbuf;
  logic                          unread;
  logic [12:0]                   reload_val;
  logic [12:0]                   cnt;
  logic                          reload_pend;
  logic                          half_ph;
  logic [1:0]                    div3;
  logic [3:0]                    flags;
  sc_pkg::sc_xfer_state_type     xs;
  sc_pkg::sc_rx_state_type       rs;
  logic [11:0]                   x_sh;
  logic [3:0]                    x_left;
  logic [3:0]                    x_ph;
  logic                          sclk;
  logic                          dout;
  logic                          tir_set;
  logic                          srx_done;
  logic [3:0]                    r_ph;
  logic [3:0]                    r_bit;
  logic                          v0;
  logic                          v1;
  logic [8:0]                    r_sh;
  logic                          stop_bad;
  logic                          r_prev;
  logic                          ar_done;
  logic                          ar_fe;
  logic                          ack;

  logic [2:0]  mode;
  logic        sync_m;
  logic        run;
  logic        ren;
  logic        uf;
  logic        tick;
  logic        acc;
  logic        wr;
  logic        wr_ctrl;
  logic        wr_tbuf;
  logic        wr_baud;
  logic        wr_flag;
  logic        rd_rbuf;
  logic        tx_load;
  logic        rx_start;
  logic        maj;
  logic [3:0]  nd;
  logic [3:0]  flen;
  logic [8:0]  fdat;
  logic [11:0] frame;
  logic [8:0]  ar_data;
  logic        rx_done;
  logic [8:0]  rx_data;
  logic        pe_hit;
  logic        fe_hit;
  logic        oe_hit;
  logic [31:0] next_dat;
  logic [15:0] baud_wr_val;

  assign mode   = ctrl[sc_pkg::CTRL_MODE_LSB +: 3];
  assign sync_m = (mode == sc_pkg::MODE_SYNC);  // see R1
  assign run    = ctrl[sc_pkg::CTRL_RUN];
  assign ren    = ctrl[sc_pkg::CTRL_REN];

  // bus decode: one access per cyc&stb request, none in the ack cycle, answered one cycle later
  assign acc     = wb_cyc_i && wb_stb_i && !ack;
  assign wr      = acc && wb_we_i;
  assign wr_ctrl = wr && (wb_adr_i == sc_pkg::REG_CTRL) && (|wb_sel_i[1:0]);
  assign wr_baud = wr && (wb_adr_i == sc_pkg::REG_BAUD) && (|wb_sel_i[1:0]);
  assign wr_flag = wr && (wb_adr_i == sc_pkg::REG_FLAG) && wb_sel_i[0];
  // writes during a pending or running sync reception are dropped
  assign wr_tbuf = wr && (wb_adr_i == sc_pkg::REG_TBUF) && wb_sel_i[0]
                   && !(sync_m && (ren || xs == sc_pkg::X_SYNC_RX));  // see R10
  assign rd_rbuf = acc && !wb_we_i && (wb_adr_i == sc_pkg::REG_RBUF);
  assign baud_wr_val = sc_merge({3'h0, reload_val}, wb_dat_i[15:0], wb_sel_i[1:0]);

  // ---------------- baud generator ----------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      half_ph <= 1'b0;
    end else begin
      half_ph <= !half_ph;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      reload_val <= sc_pkg::BAUD_RST;
    end else if (wr_baud) begin
      reload_val <= baud_wr_val[12:0];  // see R18
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt         <= sc_pkg::BAUD_RST;
      reload_pend <= 1'b0;
    end else begin
      if (run && reload_pend) begin
        cnt         <= reload_val;  // see R19
        reload_pend <= 1'b0;
      end else if (run && half_ph) begin
        cnt <= (cnt == 13'h0000) ? reload_val : cnt - 13'h0001;  // see R15 see R16
      end
      if (wr_baud) begin
        reload_pend <= 1'b1;  // see R19
      end
    end
  end

  assign uf = run && !reload_pend && half_ph && (cnt == 13'h0000);  // see R16

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div3 <= 2'h0;
    end else if (uf) begin
      div3 <= (div3 == sc_pkg::DIV3_SKIP) ? 2'h0 : div3 + 2'h1;
    end
  end

  // third select drops every third underflow
  assign tick = uf && (!ctrl[sc_pkg::CTRL_BRS] || div3 != sc_pkg::DIV3_SKIP);  // see R17

  // ---------------- async transmit frame ----------------
  always_comb begin
    unique case (mode)
      sc_pkg::MODE_7P: begin
        fdat = {1'b0, (^tbuf[6:0]) ^ ctrl[sc_pkg::CTRL_ODD], tbuf[6:0]};
        nd   = sc_pkg::DATA8;
      end
      sc_pkg::MODE_8P: begin
        fdat = {(^tbuf[7:0]) ^ ctrl[sc_pkg::CTRL_ODD], tbuf[7:0]};
        nd   = sc_pkg::DATA9;
      end
      sc_pkg::MODE_9, sc_pkg::MODE_8W: begin
        fdat = tbuf;
        nd   = sc_pkg::DATA9;
      end
      default: begin
        fdat = {1'b0, tbuf[7:0]};
        nd   = sc_pkg::DATA8;
      end
    endcase
    frame = (nd == sc_pkg::DATA8) ? {3'h7, fdat[7:0], 1'b0} : {2'h3, fdat, 1'b0};
    flen  = nd + {3'h0, ctrl[sc_pkg::CTRL_STOP2]} + 4'h2;
  end

  // idle transmitter takes the buffer at once; sync needs receiver off
  assign tx_load  = (xs == sc_pkg::X_IDLE) && tbuf_full && run
                    && !(sync_m && ren);  // see R4 see R5
  // ren still reads high in the cycle a byte completes; the guard stops a restart
  assign rx_start = (xs == sc_pkg::X_IDLE) && sync_m && run && ren && !srx_done;  // see R7 see R8

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tbuf      <= sc_pkg::BUF_RST;
      tbuf_full <= 1'b0;
    end else begin
      if (tx_load) begin
        tbuf_full <= 1'b0;  // see R5
      end
      if (wr_tbuf) begin
        tbuf      <= wb_dat_i[8:0];
        tbuf_full <= 1'b1;
      end
    end
  end

  // ---------------- transfer engine: async tx, sync tx and rx ----------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      xs       <= sc_pkg::X_IDLE;
      x_sh     <= 12'h000;
      x_left   <= 4'h0;
      x_ph     <= 4'h0;
      sclk     <= 1'b1;
      dout     <= 1'b1;
      tir_set  <= 1'b0;
      srx_done <= 1'b0;
    end else begin
      tir_set  <= 1'b0;
      srx_done <= 1'b0;
      unique case (xs)
        sc_pkg::X_IDLE: begin
          sclk <= 1'b1;
          dout <= 1'b1;
          x_ph <= 4'h0;
          if (rx_start) begin
            xs     <= sc_pkg::X_SYNC_RX;
            x_left <= sc_pkg::SYNC_BITS;  // see R2
            sclk   <= 1'b0;
          end else if (tx_load && sync_m) begin
            xs     <= sc_pkg::X_SYNC_TX;
            x_sh   <= {4'h0, tbuf[7:0]};
            x_left <= sc_pkg::SYNC_BITS;  // see R2
            dout   <= tbuf[0];
            sclk   <= 1'b0;  // see R4
          end else if (tx_load) begin
            xs     <= sc_pkg::X_ASYNC_TX;
            x_sh   <= frame;
            x_left <= flen;
            dout   <= 1'b0;
          end
        end
        sc_pkg::X_ASYNC_TX: begin
          if (tick) begin
            x_ph <= x_ph + 4'h1;  // see R20
            if (x_ph == sc_pkg::ASYNC_LAST_PH) begin
              if (x_left == 4'h1) begin
                xs   <= sc_pkg::X_IDLE;
                dout <= 1'b1;
              end else begin
                x_sh   <= {1'b1, x_sh[11:1]};
                dout   <= x_sh[1];
                x_left <= x_left - 4'h1;
                tir_set <= (x_left == 4'h2);
              end
            end
          end
        end
        sc_pkg::X_SYNC_TX: begin
          if (tick) begin
            x_ph <= x_ph + 4'h1;  // see R22
            if (x_ph[1:0] == sc_pkg::SYNC_RISE_PH) begin
              sclk <= 1'b1;
            end
            if (x_ph[1:0] == sc_pkg::SYNC_LAST_PH) begin
              x_ph <= 4'h0;
              if (x_left == 4'h1) begin
                xs      <= sc_pkg::X_IDLE;
                sclk    <= 1'b1;  // see R6
                dout    <= 1'b1;
                tir_set <= 1'b1;
              end else begin
                x_sh   <= {1'b0, x_sh[11:1]};
                dout   <= x_sh[1];  // see R25
                sclk   <= 1'b0;
                x_left <= x_left - 4'h1;
              end
            end
          end
        end
        sc_pkg::X_SYNC_RX: begin
          if (tick) begin
            x_ph <= x_ph + 4'h1;  // see R22
            if (x_ph[1:0] == sc_pkg::SYNC_RISE_PH) begin
              sclk <= 1'b1;
              x_sh <= {4'h0, rxd_i, x_sh[7:1]};  // see R25 see R7
            end
            if (x_ph[1:0] == sc_pkg::SYNC_LAST_PH) begin
              x_ph <= 4'h0;
              if (x_left == 4'h1) begin
                xs       <= sc_pkg::X_IDLE;
                sclk     <= 1'b1;
                srx_done <= 1'b1;  // see R8 see R9
              end else begin
                sclk   <= 1'b0;
                x_left <= x_left - 4'h1;
              end
            end
          end
        end
      endcase
    end
  end

  // ---------------- async receiver ----------------
  assign maj = (v0 & v1) | (v0 & rxd_i) | (v1 & rxd_i);  // see R21

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rs       <= sc_pkg::R_IDLE;
      r_ph     <= 4'h0;
      r_bit    <= 4'h0;
      v0       <= 1'b1;
      v1       <= 1'b1;
      r_sh     <= 9'h000;
      stop_bad <= 1'b0;
      r_prev   <= 1'b1;
      ar_done  <= 1'b0;
      ar_fe    <= 1'b0;
    end else begin
      r_prev  <= rxd_i;
      ar_done <= 1'b0;
      unique case (rs)
        sc_pkg::R_IDLE: begin
          if (!sync_m && run && ren && r_prev && !rxd_i) begin
            rs       <= sc_pkg::R_BUSY;
            r_ph     <= 4'h0;
            r_bit    <= 4'h0;
            stop_bad <= 1'b0;
          end
        end
        sc_pkg::R_BUSY: begin
          if (tick) begin
            r_ph <= r_ph + 4'h1;  // see R20
            if (r_ph == sc_pkg::SAMPLE_A) begin
              v0 <= rxd_i;  // see R21
            end
            if (r_ph == sc_pkg::SAMPLE_B) begin
              v1 <= rxd_i;  // see R21
            end
            if (r_ph == sc_pkg::SAMPLE_C) begin
              if (r_bit == 4'h0) begin
                if (maj) begin
                  rs <= sc_pkg::R_IDLE;
                end
              end else if (r_bit <= nd) begin
                r_sh <= {maj, r_sh[8:1]};
              end else begin
                if (!maj) begin
                  stop_bad <= 1'b1;
                end
                if (r_bit == flen - 4'h1) begin
                  rs      <= sc_pkg::R_IDLE;
                  ar_done <= 1'b1;  // see R9
                  ar_fe   <= stop_bad || !maj;
                end
              end
            end
            if (r_ph == sc_pkg::ASYNC_LAST_PH) begin
              r_bit <= r_bit + 4'h1;
            end
          end
        end
      endcase
    end
  end

  assign ar_data = (nd == sc_pkg::DATA8) ? {1'b0, r_sh[8:1]} : r_sh;

  // ---------------- completion, buffer and error status ----------------
  always_comb begin
    rx_done = srx_done || (ar_done && !(mode == sc_pkg::MODE_8W && !ar_data[8]));
    rx_data = srx_done ? {1'b0, x_sh[7:0]} : ar_data;
    pe_hit  = ar_done && rx_done && ctrl[sc_pkg::CTRL_PEN] && !sync_m
              && (((mode == sc_pkg::MODE_7P) && ((^ar_data[7:0]) != ctrl[sc_pkg::CTRL_ODD]))
              || ((mode == sc_pkg::MODE_8P) && ((^ar_data) != ctrl[sc_pkg::CTRL_ODD])));  // see R13
    fe_hit  = ar_done && rx_done && ctrl[sc_pkg::CTRL_FEN] && !sync_m && ar_fe;  // see R12
    oe_hit  = rx_done && ctrl[sc_pkg::CTRL_OEN] && unread;  // see R14
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rbuf   <= sc_pkg::BUF_RST;
      unread <= 1'b0;
    end else begin
      if (rd_rbuf) begin
        unread <= 1'b0;
      end
      if (rx_done) begin
        rbuf   <= rx_data;  // see R8 see R23
        unread <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl <= sc_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= sc_merge(ctrl, wb_dat_i[15:0], wb_sel_i[1:0]);
      end else if (srx_done) begin
        ctrl[sc_pkg::CTRL_REN] <= 1'b0;  // see R8
      end
      if (pe_hit) begin
        ctrl[sc_pkg::CTRL_PE] <= 1'b1;  // see R24
      end
      if (fe_hit) begin
        ctrl[sc_pkg::CTRL_FE] <= 1'b1;  // see R24
      end
      if (oe_hit) begin
        ctrl[sc_pkg::CTRL_OE] <= 1'b1;  // see R24
      end
    end
  end

  // request flags: write one to clear, a same-cycle event wins
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      flags <= 4'h0;
    end else begin
      if (wr_flag) begin
        flags <= flags & ~wb_dat_i[3:0];
      end
      if (tx_load) begin
        flags[sc_pkg::FLAG_TBIR] <= 1'b1;  // see R5
      end
      if (tir_set) begin
        flags[sc_pkg::FLAG_TIR] <= 1'b1;  // see R6
      end
      if (rx_done) begin
        flags[sc_pkg::FLAG_RIR] <= 1'b1;  // see R8
      end
      if (pe_hit || fe_hit || oe_hit) begin
        flags[sc_pkg::FLAG_EIR] <= 1'b1;  // see R11
      end
    end
  end

  // ---------------- bus answer ----------------
  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (wb_adr_i)
      sc_pkg::REG_CTRL: next_dat[15:0] = ctrl;
      sc_pkg::REG_TBUF: next_dat[8:0]  = tbuf;
      sc_pkg::REG_RBUF: next_dat[8:0]  = rbuf;
      sc_pkg::REG_BAUD: next_dat[12:0] = cnt;  // see R18
      sc_pkg::REG_FLAG: begin
        next_dat[3:0]                   = flags;
        next_dat[sc_pkg::FLAG_TX_BUSY]   = (xs != sc_pkg::X_IDLE) || tbuf_full;
        next_dat[sc_pkg::FLAG_RX_BUSY]   = (rs != sc_pkg::R_IDLE) || (xs == sc_pkg::X_SYNC_RX);
        next_dat[sc_pkg::FLAG_RBUF_FULL] = unread;
      end
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ack      <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack <= acc;
      if (acc && !wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // ---------------- pins ----------------
  assign wb_ack_o       = ack;
  assign txd_o          = sync_m ? sclk : dout;  // see R3
  assign rxd_o          = dout;  // see R3 see R6
  assign rxd_oe_o       = sync_m && !ren && (xs != sc_pkg::X_SYNC_RX);
  assign tx_buf_flag_o  = flags[sc_pkg::FLAG_TBIR];
  assign tx_done_flag_o = flags[sc_pkg::FLAG_TIR];
  assign rx_done_flag_o = flags[sc_pkg::FLAG_RIR];
  assign err_flag_o     = flags[sc_pkg::FLAG_EIR];

endmodule : sc_serial_channel

// [sc_serial_channel_assertions.sv]
// port-level checker for the serial channel
`timescale 1ns/1ps
module sc_chk (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        txd_o,
  input wire logic        rxd_o,
  input wire logic        rxd_oe_o,
  input wire logic        tx_buf_flag_o,
  input wire logic        tx_done_flag_o,
  input wire logic        rx_done_flag_o,
  input wire logic        err_flag_o
);
  logic [3:0] n_fall;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // shift clock falls since the current transfer began
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      n_fall <= 4'h0;
    end else begin
      n_fall <= (($rose(tx_buf_flag_o) || $fell(rxd_oe_o)) ? 4'h0 : n_fall) + {3'h0, $fell(txd_o)};
    end
  end
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_baud_top_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == sc_pkg::REG_BAUD
    |-> wb_dat_o[31:13] == 19'h0) else $error("baud read upper bits set");
  a_load_starts: assert property ($rose(tx_buf_flag_o) |-> !txd_o)
    else $error("buffer taken without shifting");
  a_tx_end_high: assert property ($rose(tx_done_flag_o) |-> txd_o && rxd_o && n_fall == 4'h8)
    else $error("bad transmit end");
  a_rx_end: assert property ($rose(rx_done_flag_o) |-> txd_o && rxd_oe_o && n_fall == 4'h8)
    else $error("bad receive end");
  a_err_with_rx: assert property ($rose(err_flag_o) |-> $rose(rx_done_flag_o))
    else $error("error flag apart from receive flag");
  a_rx_line_free: assert property (!rxd_oe_o |-> rxd_o)
    else $error("data out not idle while released");
  a_shift_stable: assert property ($rose(txd_o) |-> $stable(rxd_o))
    else $error("data changed on rising clock");
  c_tx: cover property ($rose(tx_done_flag_o));
  c_rx: cover property ($rose(rx_done_flag_o));
  c_err: cover property ($rose(err_flag_o));
endmodule : sc_chk

// [sc_shreg_model.sv]
// external shift register on the synchronous link
`timescale 1ns/1ps
module sc_shreg_model (
  input  wire logic       sclk_i,
  input  wire logic       dev_oe_i,
  input  wire logic       dev_d_i,
  input  wire logic [7:0] send_i,
  output logic            line_o,
  output logic      [7:0] got_o
);
  logic [7:0] sr;
  logic       q;
  assign line_o = dev_oe_i ? dev_d_i : q;
  initial begin
    sr = 8'h00;
    q = 1'b1;
    got_o = 8'h00;
  end
  // until the first bit the line shows the inverse of it
  always @(negedge dev_oe_i) begin
    sr = send_i;
    q = ~send_i[0];
  end
  // new bit on falling clock, lsb first
  always @(negedge sclk_i) if (!dev_oe_i) begin
    q = sr[0];
    sr = sr >> 1;
  end
  always @(posedge sclk_i) if (dev_oe_i) got_o <= {line_o, got_o[7:1]};
endmodule : sc_shreg_model

// [tb.sv]
// self-checking bench for the serial channel
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] RUN = 32'h1 << sc_pkg::CTRL_RUN;
  localparam logic [31:0] REN = 32'h1 << sc_pkg::CTRL_REN;
  localparam logic [31:0] OEN = 32'h1 << sc_pkg::CTRL_OEN;
  localparam logic [31:0] OVR = 32'h1 << sc_pkg::CTRL_OE;
  localparam logic [31:0] BRS = 32'h1 << sc_pkg::CTRL_BRS;
  logic        clk_i = 1'b0, nrst_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00, m_send = 8'h00, m_got;
  logic [3:0]  sel = 4'h0, fl;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic        ack, txd, rxd, rxd_o, oe;
  int          n_errors = 0, n_checks = 0, cyc_n = 0, k;
  always #12.5 clk_i = ~clk_i;
  sc_serial_channel uut (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .txd_o(txd), .rxd_i(rxd), .rxd_o(rxd_o), .rxd_oe_o(oe),
    .tx_buf_flag_o(fl[0]), .tx_done_flag_o(fl[1]), .rx_done_flag_o(fl[2]), .err_flag_o(fl[3]));
  sc_shreg_model pm (.sclk_i(txd), .dev_oe_i(oe), .dev_d_i(rxd_o), .send_i(m_send),
    .line_o(rxd), .got_o(m_got));
  task check(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, sel} <= {2'b11, w, 4'hf};
    {adr, dat} <= {a, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q, e);
  endtask : rdc
  task waitf(input int b);
    for (k = 0; k < 400 && fl[b] !== 1'b1; k++) @(posedge clk_i);
  endtask : waitf
  task t_reset;
    check({txd, oe, rxd_o, fl}, 7'h70);
    rdc(sc_pkg::REG_CTRL, 32'h0);
    rdc(8'h20, 32'h0);
    wb(1'b1, sc_pkg::REG_CTRL, 32'h1);
    check(oe, 1'b0);
    wb(1'b1, sc_pkg::REG_CTRL, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task t_baud;
    wb(1'b1, sc_pkg::REG_BAUD, 32'hffff_2005);
    rdc(sc_pkg::REG_BAUD, 32'h0);
    wb(1'b1, sc_pkg::REG_CTRL, RUN);
    wb(1'b0, sc_pkg::REG_BAUD, 32'h0);
    check(q inside {[32'h3:32'h5]}, 1'b1);
    wb(1'b1, sc_pkg::REG_BAUD, 32'h0);
    rdc(sc_pkg::REG_BAUD, 32'h0);
    $display("test baud done");
  endtask : t_baud
  task t_tx;
    wb(1'b1, sc_pkg::REG_FLAG, 32'hf);
    wb(1'b1, sc_pkg::REG_TBUF, 32'h1a5);
    for (k = 0; k < 20 && txd !== 1'b0; k++) @(posedge clk_i);
    check(k <= 8, 1'b1);
    waitf(1);
    check({fl[0], txd, rxd_o}, 3'h7);
    check(m_got, 8'ha5);
    $display("test transmit done");
  endtask : t_tx
  task t_rx;
    m_send <= 8'h3c;
    wb(1'b1, sc_pkg::REG_CTRL, RUN | REN | OEN);
    waitf(2);
    rdc(sc_pkg::REG_RBUF, 32'h3c);
    rdc(sc_pkg::REG_CTRL, RUN | OEN);
    $display("test receive done");
  endtask : t_rx
  task t_ovr;
    wb(1'b1, sc_pkg::REG_FLAG, 32'hf);
    m_send <= 8'h5a;
    wb(1'b1, sc_pkg::REG_CTRL, RUN | REN | OEN);
    waitf(2);
    wb(1'b1, sc_pkg::REG_FLAG, 32'hf);
    m_send <= 8'hc3;
    wb(1'b1, sc_pkg::REG_CTRL, RUN | REN | OEN);
    wb(1'b1, sc_pkg::REG_TBUF, 32'h77);
    wb(1'b1, sc_pkg::REG_CTRL, RUN | OEN);
    waitf(2);
    check(fl, 4'hc);
    rdc(sc_pkg::REG_CTRL, RUN | OEN | OVR);
    rdc(sc_pkg::REG_RBUF, 32'hc3);
    wb(1'b1, sc_pkg::REG_FLAG, 32'hf);
    rdc(sc_pkg::REG_CTRL, RUN | OEN | OVR);
    wb(1'b1, sc_pkg::REG_CTRL, RUN | OEN);
    rdc(sc_pkg::REG_CTRL, RUN | OEN);
    $display("test overrun done");
  endtask : t_ovr
  task t_third;
    wb(1'b1, sc_pkg::REG_FLAG, 32'hf);
    wb(1'b1, sc_pkg::REG_CTRL, RUN | BRS);
    wb(1'b1, sc_pkg::REG_TBUF, 32'h96);
    for (k = 0; k < 200 && fl[1] !== 1'b1; k++) @(posedge clk_i);
    check(k inside {[90:104]}, 1'b1);
    check(m_got, 8'h96);
    $display("test third select done");
  endtask : t_third
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset;
    t_baud;
    t_tx;
    t_rx;
    t_ovr;
    t_third;
    wrap_up;
  end
endmodule : tb
bind sc_serial_channel sc_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .txd_o(txd_o), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o),
  .tx_buf_flag_o(tx_buf_flag_o), .tx_done_flag_o(tx_done_flag_o),
  .rx_done_flag_o(rx_done_flag_o), .err_flag_o(err_flag_o));
